/* File: rtl/uis_params.svh */
`ifndef UIS_PARAMS_SVH
`define UIS_PARAMS_SVH

// Register byte offsets
`define UIS_ADDR_W        12
`define UIS_OFS_MASK      12'h038
`define UIS_OFS_RAW       12'h03c
`define UIS_OFS_MASKED    12'h040
`define UIS_OFS_CLEAR     12'h044

// Flag field positions, common to all four registers
`define UIS_BIT_OVERRUN   10
`define UIS_BIT_BREAK     9
`define UIS_BIT_PARITY    8
`define UIS_BIT_FRAMING   7
`define UIS_BIT_RX_TMO    6
`define UIS_BIT_TX_LEVEL  5
`define UIS_BIT_RX_LEVEL  4
`define UIS_FLAG_MSB      10
`define UIS_FLAG_LSB      4
`define UIS_NUM_FLAGS     7

// Reset values
`define UIS_FLAGS_RST     7'h00
`define UIS_MASK_RST      7'h00
`define UIS_RAW_LOW_RST   4'hf
`define UIS_MASKED_LOW    4'h0

// Bus answers
`define UIS_RESP_OKAY     2'h0
`define UIS_RESP_SLVERR   2'h2

`endif

/* File: rtl/uis_pkg.sv */
`include "uis_params.svh"

package uis_pkg;

   // Error and time-out events, one-cycle pulses from the receiver
   typedef struct packed {
      logic overrun;
      logic brk;
      logic parity;
      logic framing;
      logic rx_timeout;
   } uis_err_s;

   // Seven flags in register order, overrun at the top
   typedef struct packed {
      logic overrun;
      logic brk;
      logic parity;
      logic framing;
      logic rx_timeout;
      logic tx_level;
      logic rx_level;
   } uis_flags_s;

   // Flag bank state
   typedef struct packed {
      uis_flags_s flags;
   } uis_bank_s;

   // Top-level state: bus slave, mask, edge history, interrupt line
   typedef struct packed {
      logic [`UIS_NUM_FLAGS-1:0] mask;
      logic                      tx_past_d;
      logic                      rx_past_d;
      logic                      aw_held;
      logic [`UIS_ADDR_W-1:0]    aw_addr;
      logic                      w_held;
      logic [31:0]               w_data;
      logic [3:0]                w_strb;
      logic                      awready;
      logic                      wready;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      arready;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
      logic                      irq;
   } uis_state_s;

endpackage

/* File: rtl/uis_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"

module uis_flag_bank (
   input  wire logic              clk,   // System clock
   input  wire logic              rst,   // Synchronous reset, high
   input  wire uis_pkg::uis_flags_s set_v, // Per-flag set pulses
   input  wire uis_pkg::uis_flags_s clr_v, // Per-flag clear pulses
   output var  uis_pkg::uis_flags_s flags  // Sticky raw flags
);
   import uis_pkg::*;

   uis_bank_s                 s;
   uis_bank_s                 next_s;
   logic [`UIS_NUM_FLAGS-1:0] next_bit;

   // Per flag: set beats a clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < `UIS_NUM_FLAGS; i = i + 1) begin : g_flag
         assign next_bit[i] = set_v[i] | (s.flags[i] & ~clr_v[i]); // RQ9
      end
   endgenerate

   // Next state
   always_comb begin
      next_s       = s;
      next_s.flags = uis_flags_s'(next_bit);
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s.flags <= uis_flags_s'(`UIS_FLAGS_RST); // RQ2 RQ3
      end else begin
         s <= next_s;
      end
   end

   assign flags = s.flags;

endmodule

`default_nettype wire

/* File: rtl/uis_top.sv */
// Operation
// RQ1: Reading raw status at 0x03C gives unmasked flags; writes ignored. The code also clears all seven raw flags on that read.
// RQ2: Raw overrun bit 10, break 9, parity 8, framing 7; reset 0.
// RQ3: Raw time-out bit 6, transmit level 5, receive level 4; reset 0.
// RQ4: Raw status bits 3:0 read-only, read as all ones.
// RQ5: Software leaves reserved upper bits alone and ignores their value.
// RQ6: Reading masked status at 0x040 gives masked flags; writes ignored.
// RQ7: Masked flags at the same positions; they and bits 3:0 reset 0.
// RQ8: Mask at 0x038 gates each raw flag; masked equals raw AND mask.
// RQ9: Writing one to clear register 0x044 clears a flag; zero does nothing.
// RQ10: Level interrupts fire on crossing the trigger point, not while beyond.
// RQ11: One combined interrupt request, OR of all masked flags.
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"

module uis_top (
   input  wire logic                   clk,            // System clock
   input  wire logic                   rst,            // Sync reset, high
   // AXI4-Lite write address
   input  wire logic [`UIS_ADDR_W-1:0] s_axi_awaddr,   // Write address
   input  wire logic                   s_axi_awvalid,  // Address valid
   output var  logic                   s_axi_awready,  // Address taken
   // AXI4-Lite write data
   input  wire logic [31:0]            s_axi_wdata,    // Write data
   input  wire logic [3:0]             s_axi_wstrb,    // Byte enables
   input  wire logic                   s_axi_wvalid,   // Data valid
   output var  logic                   s_axi_wready,   // Data taken
   // AXI4-Lite write response
   output var  logic [1:0]             s_axi_bresp,    // Write answer
   output var  logic                   s_axi_bvalid,   // Answer valid
   input  wire logic                   s_axi_bready,   // Answer taken
   // AXI4-Lite read address
   input  wire logic [`UIS_ADDR_W-1:0] s_axi_araddr,   // Read address
   input  wire logic                   s_axi_arvalid,  // Address valid
   output var  logic                   s_axi_arready,  // Address taken
   // AXI4-Lite read data
   output var  logic [31:0]            s_axi_rdata,    // Read data
   output var  logic [1:0]             s_axi_rresp,    // Read answer
   output var  logic                   s_axi_rvalid,   // Data valid
   input  wire logic                   s_axi_rready,   // Data taken
   // Event sources from the serial port logic
   input  wire uis_pkg::uis_err_s      err_event,      // Error pulses
   input  wire logic                   tx_past_level,  // TX fill at trigger
   input  wire logic                   rx_past_level,  // RX fill at trigger
   // Interrupt request
   output var  logic                   irq             // Combined request
);
   import uis_pkg::*;

   uis_state_s  s;
   uis_state_s  next_s;
   uis_flags_s  raw;
   uis_flags_s  set_v;
   uis_flags_s  clr_v;
   uis_flags_s  masked;

   logic        tx_cross;
   logic        rx_cross;
   logic        wr_fire;
   logic        rd_fire;
   logic [31:0] wr_bmask;
   logic [31:0] wr_bits;
   logic [`UIS_NUM_FLAGS-1:0] wr_flag_en;
   logic [`UIS_NUM_FLAGS-1:0] wr_flag_val;
   logic [`UIS_ADDR_W-1:0]    wr_word;
   logic [`UIS_ADDR_W-1:0]    rd_word;

   // Sticky raw flags
   uis_flag_bank u_bank (
      .clk   (clk),
      .rst   (rst),
      .set_v (set_v),
      .clr_v (clr_v),
      .flags (raw)
   );

   // Fill level crossings: rising edge of the at-trigger condition
   assign tx_cross = tx_past_level & ~s.tx_past_d; // RQ10
   assign rx_cross = rx_past_level & ~s.rx_past_d; // RQ10

   // Set vector, positions follow the register layout
   always_comb begin
      set_v            = '0;
      set_v.overrun    = err_event.overrun;    // RQ2
      set_v.brk        = err_event.brk;        // RQ2
      set_v.parity     = err_event.parity;     // RQ2
      set_v.framing    = err_event.framing;    // RQ2
      set_v.rx_timeout = err_event.rx_timeout; // RQ3
      set_v.tx_level   = tx_cross;             // RQ3
      set_v.rx_level   = rx_cross;             // RQ3
   end

   // Masked view of the raw flags
   assign masked = uis_flags_s'(raw & s.mask); // RQ8

   // Word-aligned byte addresses, low two address bits ignored
   assign wr_word = {s.aw_addr[`UIS_ADDR_W-1:2], 2'b00};
   assign rd_word = {s_axi_araddr[`UIS_ADDR_W-1:2], 2'b00};

   // A write completes once address and data are both held
   assign wr_fire = s.aw_held & s.w_held & ~s.bvalid;
   assign rd_fire = s_axi_arvalid & s.arready;

   // Byte enables widened to bit enables
   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1) begin : g_byte
         assign wr_bmask[8*b+7:8*b] = {8{s.w_strb[b]}};
      end
   endgenerate
   assign wr_bits  = s.w_data & wr_bmask;
   assign wr_flag_en  = wr_bmask[`UIS_FLAG_MSB:`UIS_FLAG_LSB];
   assign wr_flag_val = wr_bits[`UIS_FLAG_MSB:`UIS_FLAG_LSB];

   // Clear vector: one written to the clear register, or a raw read
   always_comb begin
      clr_v = '0;
      if (wr_fire && wr_word == `UIS_OFS_CLEAR) begin
         clr_v = uis_flags_s'(wr_flag_val); // RQ9
      end
      if (rd_fire && rd_word == `UIS_OFS_RAW) begin
         clr_v = uis_flags_s'({`UIS_NUM_FLAGS{1'b1}});
      end
   end

   // Next state: bus slave, mask register, edge history, interrupt
   always_comb begin
      next_s = s;

      // Edge history for the level crossings
      next_s.tx_past_d = tx_past_level;
      next_s.rx_past_d = rx_past_level;

      // Write response taken
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // Capture write address and data independently
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end

      // Perform the write and answer it
      if (wr_fire) begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = `UIS_RESP_OKAY;
         unique case (wr_word)
            `UIS_OFS_MASK: begin
               next_s.mask = (s.mask & ~wr_flag_en) | wr_flag_val; // RQ8
            end
            `UIS_OFS_RAW: begin
               next_s.bresp = `UIS_RESP_OKAY; // RQ1
            end
            `UIS_OFS_MASKED: begin
               next_s.bresp = `UIS_RESP_OKAY; // RQ6
            end
            `UIS_OFS_CLEAR: begin
               next_s.bresp = `UIS_RESP_OKAY;
            end
            default: begin
               next_s.bresp = `UIS_RESP_SLVERR;
            end
         endcase
      end

      // Each side ready again only when its own capture is free and no answer waits
      next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
      next_s.wready  = ~next_s.w_held & ~next_s.bvalid;

      // Read data taken
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // Read decode, reserved upper bits read as zero
      if (rd_fire) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `UIS_RESP_OKAY;
         next_s.rdata  = 32'h0;
         unique case (rd_word)
            `UIS_OFS_MASK: begin
               next_s.rdata[`UIS_FLAG_MSB:`UIS_FLAG_LSB] = s.mask;
            end
            `UIS_OFS_RAW: begin
               next_s.rdata[`UIS_FLAG_MSB:`UIS_FLAG_LSB] = raw; // RQ1
               next_s.rdata[3:0] = `UIS_RAW_LOW_RST;            // RQ4
            end
            `UIS_OFS_MASKED: begin
               next_s.rdata[`UIS_FLAG_MSB:`UIS_FLAG_LSB] = masked; // RQ6
               next_s.rdata[3:0] = `UIS_MASKED_LOW;                // RQ7
            end
            `UIS_OFS_CLEAR: begin
               next_s.rdata = 32'h0;
            end
            default: begin
               next_s.rresp = `UIS_RESP_SLVERR;
            end
         endcase
      end
      next_s.arready = ~next_s.rvalid;

      // Combined request from the masked flags
      next_s.irq = |masked; // RQ11
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s.mask      <= `UIS_MASK_RST;
         s.tx_past_d <= 1'b0;
         s.rx_past_d <= 1'b0;
         s.aw_held   <= 1'b0;
         s.aw_addr   <= '0;
         s.w_held    <= 1'b0;
         s.w_data    <= 32'h0;
         s.w_strb    <= 4'h0;
         s.awready   <= 1'b0;
         s.wready    <= 1'b0;
         s.bvalid    <= 1'b0;
         s.bresp     <= `UIS_RESP_OKAY;
         s.arready   <= 1'b0;
         s.rvalid    <= 1'b0;
         s.rdata     <= 32'h0;
         s.rresp     <= `UIS_RESP_OKAY;
         s.irq       <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s.awready;
   assign s_axi_wready  = s.wready;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;
   assign irq           = s.irq;

endmodule

`default_nettype wire

/* File: dv/uis_event_src.sv */
`timescale 1ns/1ps
`default_nettype none

module uis_event_src (
   input  wire logic              clk,       // System clock
   input  wire uis_pkg::uis_err_s req,       // Events asked for
   output var  uis_pkg::uis_err_s err_event  // Event pulses out
);
   import uis_pkg::*;

   // One clean pulse per request, launched on the block's clock
   always_ff @(posedge clk) begin
      err_event <= req;
   end
endmodule

`default_nettype wire

/* File: dv/uis_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"

module uis_checker (
   input  wire logic                   clk,           // Clock
   input  wire logic                   rst,           // Reset
   input  wire logic [`UIS_ADDR_W-1:0] s_axi_araddr,  // Read address
   input  wire logic                   s_axi_arvalid, // Address valid
   input  wire logic                   s_axi_arready, // Address taken
   input  wire logic [31:0]            s_axi_rdata,   // Read data
   input  wire logic                   s_axi_rvalid,  // Data valid
   input  wire logic                   s_axi_rready,  // Data taken
   input  wire logic                   s_axi_awvalid, // Address valid
   input  wire logic                   s_axi_awready, // Address taken
   input  wire logic                   s_axi_wvalid,  // Data valid
   input  wire logic                   s_axi_wready,  // Data taken
   input  wire logic [1:0]             s_axi_bresp,   // Write answer
   input  wire logic                   s_axi_bvalid,  // Answer valid
   input  wire logic                   s_axi_bready,  // Answer taken
   input  wire logic                   irq            // Interrupt
);
   logic [`UIS_ADDR_W-1:0] ar_q;

   // Address of the read under way
   always_ff @(posedge clk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_start;
      $rose(s_axi_rvalid);
   endsequence

   reset_quiet_a: assert property (
      $fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("outputs active after reset");
   read_answer_a: assert property (
      rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered in one cycle");
   write_answer_a: assert property (
      wr_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer not at second edge");
   read_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   write_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before taken");
   raw_low_a: assert property (
      rd_start ##0 (ar_q == `UIS_OFS_RAW) |->
         s_axi_rdata[3:0] == `UIS_RAW_LOW_RST)
      else $error("raw status low bits not all ones");
   masked_low_a: assert property (
      rd_start ##0 (ar_q == `UIS_OFS_MASKED) |->
         s_axi_rdata[3:0] == `UIS_MASKED_LOW)
      else $error("masked status low bits not zero");
   irq_match_a: assert property (
      rd_start ##0 (ar_q == `UIS_OFS_MASKED) |-> irq == |s_axi_rdata[10:4])
      else $error("interrupt differs from masked flags");
endmodule

bind uis_top uis_checker chk_i (.clk, .rst, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .irq);

`default_nettype wire

/* File: dv/uis_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"

module uis_top_bench;
   import uis_pkg::*;
   logic clk = 0, rst = 1, irq;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lv = 0;
   uis_err_s ev_req = '0, err_event;
   int err_count = 0, n_tests = 0;
   logic lazy = 1'b0; // Ready raised only after valid is seen

   uis_event_src src (.clk, .req(ev_req), .err_event);
   uis_top dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .err_event, .tx_past_level(lv[1]),
      .rx_past_level(lv[0]), .irq);

   // 100 MHz clock
   always #5 clk = ~clk;

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic ta, tw, tv, tb = 0;
      logic [1:0] rs;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !lazy;
      for (int n = 0; n < 99 && !tb; n++) begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tv = s_axi_bvalid;
         tb = s_axi_bvalid && s_axi_bready;
         rs = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         s_axi_bready <= !tb && (!lazy || tv);
      end
      chk("bresp", {30'h0, r}, tb ? {30'h0, rs} : 'x);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      logic ta, tv, tr = 0;
      logic [31:0] d;
      logic [1:0] rs;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !lazy;
      for (int n = 0; n < 99 && !tr; n++) begin
         #1;
         ta = s_axi_arvalid && s_axi_arready;
         tv = s_axi_rvalid;
         tr = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         s_axi_rready <= !tr && (!lazy || tv);
      end
      chk("rdata", e, tr ? d : 'x);
      chk("rresp", {30'h0, r}, {30'h0, rs});
   endtask

   // Pulse events, then allow flag and interrupt to settle
   task ev(input logic [4:0] v);
      @(posedge clk);
      ev_req <= uis_err_s'(v);
      @(posedge clk);
      ev_req <= '0;
      repeat (3) @(posedge clk);
   endtask

   task chkirq(input logic e);
      #1;
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task results;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [31:0] b;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`UIS_OFS_RAW, 32'hf, 2'h0);
      rd(`UIS_OFS_MASKED, 32'h0, 2'h0);
      rd(`UIS_OFS_MASK, 32'h0, 2'h0);
      wr(`UIS_OFS_RAW, 32'h7f0, 2'h0);
      wr(`UIS_OFS_MASKED, 32'h7f0, 2'h0);
      rd(`UIS_OFS_RAW, 32'hf, 2'h0);
      rd(`UIS_OFS_MASKED, 32'h0, 2'h0);
      lazy = 1'b1;
      wr(`UIS_OFS_MASK, 32'h7f0, 2'h0);
      rd(`UIS_OFS_MASK, 32'h7f0, 2'h0);
      lazy = 1'b0;
      for (int i = 0; i < 5; i++) begin
         b = 32'h400 >> i;
         ev(5'h10 >> i);
         chkirq(1'b1);
         rd(`UIS_OFS_MASKED, b, 2'h0);
         wr(`UIS_OFS_CLEAR, 32'h0, 2'h0);
         rd(`UIS_OFS_MASKED, b, 2'h0);
         wr(`UIS_OFS_CLEAR, b, 2'h0);
         rd(`UIS_OFS_MASKED, 32'h0, 2'h0);
         chkirq(1'b0);
         ev(5'h10 >> i);
         rd(`UIS_OFS_RAW, b | 32'hf, 2'h0);
      end
      // Level flags fire once on the rising crossing only
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         lv <= 2'b10 >> j;
         repeat (3) @(posedge clk);
         rd(`UIS_OFS_RAW, (32'h20 >> j) | 32'hf, 2'h0);
         repeat (3) @(posedge clk);
         rd(`UIS_OFS_RAW, 32'hf, 2'h0);
         @(posedge clk);
         lv <= 2'b00;
      end
      // Only byte 0 enabled: mask bits 7:4 cleared, 10:8 kept
      s_axi_wstrb <= 4'h1;
      wr(`UIS_OFS_MASK, 32'h0, 2'h0);
      rd(`UIS_OFS_MASK, 32'h700, 2'h0);
      s_axi_wstrb <= 4'hf;
      wr(`UIS_OFS_MASK, 32'h0, 2'h0);
      ev(5'h10);
      chkirq(1'b0);
      rd(`UIS_OFS_MASKED, 32'h0, 2'h0);
      rd(`UIS_OFS_RAW, 32'h40f, 2'h0);
      rd(12'h100, 32'h0, `UIS_RESP_SLVERR);
      wr(12'h100, 32'h1, `UIS_RESP_SLVERR);
      results;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      results;
   end
endmodule

`default_nettype wire
